// [src/watchdog_and_reset_control.v]
`timescale 1ns/1ps
`default_nettype none
`include "wdt_reset_map.vh"
module watchdog_and_reset_control #(
  parameter SOFT_CYCLES = `SOFT_RESET_CYCLES,
  parameter PIN_CYCLES  = `PIN_RELEASE_CYCLES,
  parameter SLOW_DIV    = `SLOW_DIV_CYCLES
) (
  // clock and reset
  input  wire        CLOCK,
  input  wire        RST_N,
  // apb slave
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [11:0] PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  // core side
  input  wire        SLEEP_MODE,
  input  wire        EXTERNAL_CLEAR_PIN_N,
  output reg         FULL_RESET,
  output reg         WARM_RESET,
  output reg         CORE_INHIBIT,
  output reg         PORT_PRESET,
  output reg         CLEAR_PC,
  output reg         PIN_RESET_SELECT
);

  // bus decode
  wire        setup_wr = PSEL & ~PENABLE & PWRITE;
  wire        acc      = PSEL & PENABLE & PREADY;
  wire        wr       = acc & PWRITE;
  wire        sel_ctrl = (PADDR == `ADDR_WATCHDOG_CONTROL);
  wire        sel_flag = (PADDR == `ADDR_RESET_SOURCE_FLAGS);
  wire        sel_key  = (PADDR == `ADDR_RESET_PIN_KEY);
  wire        sel_stat = (PADDR == `ADDR_CORE_STATUS);
  wire        sel_ev   = (PADDR == `ADDR_CORE_EVENTS);
  wire        mapped   = sel_ctrl | sel_flag | sel_key | sel_stat | sel_ev;

  reg  [7:0]  ctrl_q;
  reg  [3:0]  flags_q;
  reg  [7:0]  pkey_q;
  reg         expired_q;
  reg         pdown_q;
  reg  [15:0] wdt_q;
  reg  [15:0] div_q;
  reg  [15:0] soft_q;
  reg  [15:0] rel_q;
  reg  [2:0]  pin_sync_q;
  reg         pin_low_q;
  reg         por_done_q;
  reg  [3:0]  flags_d;
  reg  [15:0] wdt_d;
  reg  [15:0] soft_d;
  reg  [15:0] rel_d;

  wire [4:0]  wkey  = ctrl_q[`KEY_LSB +: 5];
  wire [2:0]  wsel  = ctrl_q[`SEL_LSB +: 3];
  wire        wkey_ok = (wkey == `WDT_KEY_A) | (wkey == `WDT_KEY_B);
  wire        pkey_ok = (pkey_q == `PIN_KEY_POR) | (pkey_q == `PIN_KEY_B);
  wire        slow_tick = (div_q == SLOW_DIV - 1);
  wire        clr_instr = wr & sel_ev & PWDATA[`EV_CLEAR_WDT];
  wire        stop_instr = wr & sel_ev & PWDATA[`EV_STOP];
  // pin level counts once stages two and three agree
  wire        pin_low_d = (pin_sync_q[1] == pin_sync_q[2]) ?
                          ~pin_sync_q[2] : pin_low_q;
  wire        pin_hold = pin_low_q & pkey_ok;
  // overflow when selected bit falls, counter keeps counting unless the watchdog key is bad
  wire [4:0]  bit_idx = 5'd8 + {2'b00, wsel} - 5'd1;
  wire        wdt_next_bit = wdt_q[bit_idx[3:0]];
  wire [15:0] wdt_inc = wdt_q + 16'h0001;
  wire        overflow = slow_tick & wkey_ok & wdt_next_bit &
                         ~wdt_inc[bit_idx[3:0]];
  wire        soft_fire = (soft_q == 16'h0001);
  wire        full_evt  = soft_fire | (overflow & ~SLEEP_MODE);
  wire        warm_evt  = overflow & SLEEP_MODE;
  wire        any_reset = full_evt | warm_evt | pin_hold;
  // bad key written or settled starts one shared delay
  wire        bad_key   = ~wkey_ok | ~pkey_ok;

  // idle high after reset so no false pin event follows release
  always @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      pin_sync_q <= 3'b111;
    else
      pin_sync_q <= {pin_sync_q[1:0], EXTERNAL_CLEAR_PIN_N};
  end

  always @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      pin_low_q   <= 1'b0;
      por_done_q  <= 1'b0;
      PORT_PRESET <= 1'b1;
    end
    else
    begin
      pin_low_q   <= pin_low_d;
      por_done_q  <= 1'b1;
      // ports stay preset for one cycle past release
      PORT_PRESET <= ~por_done_q;
    end
  end

  // no wait state: ready rises the cycle after setup
  always @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      PRDATA  <= 32'h0000_0000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY  <= PSEL & ~PENABLE;
      PSLVERR <= PSEL & ~PENABLE & ~mapped;
      if (PSEL & ~PENABLE & ~PWRITE)
      begin
        case (1'b1)
          sel_ctrl: PRDATA <= {24'h0, ctrl_q};
          sel_flag: PRDATA <= {28'h0, flags_q};
          sel_key:  PRDATA <= {24'h0, pkey_q};
          sel_stat: PRDATA <= {30'h0, pdown_q, expired_q};
          default:  PRDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

  // slow rate is an enable pulse, not a second clock
  always @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      div_q <= 16'h0000;
    else
      div_q <= slow_tick ? 16'h0000 : div_q + 16'h0001;
  end

  // a bad watchdog key returns control to its power-on value
  always @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      ctrl_q <= `WDT_CTRL_POR;
    else if (soft_fire & ~wkey_ok)
      ctrl_q <= `WDT_CTRL_POR;
    else if (wr & sel_ctrl)
      ctrl_q <= PWDATA[7:0];
  end

  // key restore on all resets except warm
  always @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      pkey_q <= `PIN_KEY_POR;
    else if (full_evt | pin_hold)
      pkey_q <= `PIN_KEY_POR;
    else if (wr & sel_key)
      pkey_q <= PWDATA[7:0];
  end

  always @*
  begin
    flags_d = flags_q;
    // software may write 0 only, hardware set wins
    if (wr & sel_flag)
      flags_d = flags_q & PWDATA[3:0];
    if (soft_fire & ~wkey_ok)
      flags_d[`FLAG_WDT_SW] = 1'b1;
    if (soft_fire & ~pkey_ok)
      flags_d[`FLAG_PIN_KEY] = 1'b1;
  end

  always @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      flags_q <= 4'h0;
    else
      flags_q <= flags_d;
  end

  // status flags; clear instruction drops power-down
  always @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      expired_q <= 1'b0;
      pdown_q   <= 1'b0;
    end
    else
    begin
      if (clr_instr)
        pdown_q <= 1'b0;
      if (stop_instr)
      begin
        pdown_q   <= 1'b1;
        expired_q <= 1'b0;
      end
      if (overflow)
        expired_q <= 1'b1;
    end
  end

  // watchdog counter clear sources
  always @*
  begin
    wdt_d = wdt_q;
    if (soft_fire | clr_instr | stop_instr | pin_hold)
      wdt_d = 16'h0000;
    else if (slow_tick & wkey_ok)
      wdt_d = wdt_inc;
  end

  always @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      wdt_q <= 16'h0000;
    else
      wdt_q <= wdt_d;
  end

  // one shared soft reset delay for both key registers
  always @*
  begin
    soft_d = soft_q;
    if (soft_fire)
      soft_d = 16'h0000;
    else if (bad_key & (soft_q == 16'h0000) & ~setup_wr)
      soft_d = SOFT_CYCLES[15:0];
    else if (soft_q > 16'h0001)
      soft_d = soft_q - 16'h0001;
  end

  always @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      soft_q <= 16'h0000;
    else
      soft_q <= soft_d;
  end

  // inhibit through reset and release delay
  always @*
  begin
    rel_d = rel_q;
    if (any_reset)
      rel_d = PIN_CYCLES[15:0];
    else if (rel_q != 16'h0000)
      rel_d = rel_q - 16'h0001;
  end

  always @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      rel_q <= 16'h0000;
    else
      rel_q <= rel_d;
  end

  // requests leave through flip-flops so the core sees clean levels
  always @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      FULL_RESET       <= 1'b0;
      WARM_RESET       <= 1'b0;
      CORE_INHIBIT     <= 1'b1;
      CLEAR_PC         <= 1'b1;
      PIN_RESET_SELECT <= 1'b1;
    end
    else
    begin
      CORE_INHIBIT     <= any_reset | (rel_q > 16'h0001);
      FULL_RESET       <= full_evt | pin_hold;
      WARM_RESET       <= warm_evt;
      CLEAR_PC         <= any_reset;
      PIN_RESET_SELECT <= pkey_ok;
    end
  end

endmodule // watchdog_and_reset_control
`default_nettype wire

// [src/wdt_reset_map.vh]
`ifndef WDT_RESET_MAP_VH
`define WDT_RESET_MAP_VH
// register byte addresses on the bus
`define ADDR_WATCHDOG_CONTROL    12'h000
`define ADDR_RESET_SOURCE_FLAGS  12'h004
`define ADDR_RESET_PIN_KEY       12'h008
`define ADDR_CORE_STATUS         12'h00c
`define ADDR_CORE_EVENTS         12'h010
// watchdog_control fields and power-on value
`define KEY_LSB                  3
`define SEL_LSB                  0
`define WDT_CTRL_POR             8'h53
`define WDT_KEY_A                5'h0a
`define WDT_KEY_B                5'h15
// reset_source_flags bit positions
`define FLAG_WDT_SW              0
`define FLAG_UV_KEY              1
`define FLAG_UV                  2
`define FLAG_PIN_KEY             3
// reset_pin_key values
`define PIN_KEY_POR              8'h55
`define PIN_KEY_B                8'haa
// core_status bit positions
`define STAT_EXPIRED             0
`define STAT_PDOWN               1
// core_events write bits (self clearing)
`define EV_CLEAR_WDT             0
`define EV_STOP                  1
// timing
`define CLK_PERIOD_NS            8
`define SOFT_RESET_DELAY_NS      16000
`define SOFT_RESET_CYCLES        (`SOFT_RESET_DELAY_NS / `CLK_PERIOD_NS)
`define PIN_RELEASE_DELAY_NS     16000
`define PIN_RELEASE_CYCLES       (`PIN_RELEASE_DELAY_NS / `CLK_PERIOD_NS)
`define SLOW_OSC_HZ              32000
`define CLK_HZ                   125000000
`define SLOW_DIV_CYCLES          (`CLK_HZ / `SLOW_OSC_HZ)
`endif

// [verification/wdt_rst_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module wdt_rst_chk (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // bus
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // core side
  input wire logic SLEEP_MODE,
  input wire logic EXTERNAL_CLEAR_PIN_N,
  input wire logic FULL_RESET,
  input wire logic WARM_RESET,
  input wire logic CORE_INHIBIT,
  input wire logic PORT_PRESET,
  input wire logic CLEAR_PC,
  input wire logic PIN_RESET_SELECT
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  // four lows outlast the three-stage pin synchroniser
  sequence pin_held;
    (PIN_RESET_SELECT && !EXTERNAL_CLEAR_PIN_N) [*4];
  endsequence
  sequence pin_let_go;
    pin_held ##1 EXTERNAL_CLEAR_PIN_N;
  endsequence
  a_pin_resets: assert property (pin_held |-> ##[0:3] FULL_RESET)
    else $error("pin reset missing");
  a_pin_release_wait: assert property (pin_let_go |-> CORE_INHIBIT [*3])
    else $error("core resumed early");
  a_full_clears_pc: assert property (FULL_RESET |-> ##[0:2] CLEAR_PC)
    else $error("pc kept on full reset");
  a_full_inhibits: assert property (FULL_RESET |-> ##[0:2] CORE_INHIBIT)
    else $error("core runs in reset");
  a_warm_clears_pc: assert property (WARM_RESET |-> ##[0:2] CLEAR_PC)
    else $error("pc kept on warm reset");
  a_warm_in_sleep: assert property (WARM_RESET |-> $past(SLEEP_MODE) && !FULL_RESET)
    else $error("warm reset out of sleep");
  a_warm_pulse: assert property (WARM_RESET |=> !WARM_RESET)
    else $error("warm reset too long");
  a_preset_por: assert property ($rose(RST_N) |-> PORT_PRESET)
    else $error("ports not preset");
  a_ready_setup: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready");
  a_err_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
endmodule // wdt_rst_chk
bind watchdog_and_reset_control wdt_rst_chk chk_u (.CLOCK, .RST_N, .PSEL,
  .PENABLE, .PREADY, .PSLVERR, .SLEEP_MODE, .EXTERNAL_CLEAR_PIN_N,
  .FULL_RESET, .WARM_RESET, .CORE_INHIBIT, .PORT_PRESET, .CLEAR_PC,
  .PIN_RESET_SELECT);
`default_nettype wire

// [verification/watchdog_and_reset_control_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "wdt_reset_map.vh"
module watchdog_and_reset_control_bench;
  logic        clock = 0;
  logic        rst_n = 0;
  logic        psel = 0, penable = 0, pwrite = 0, sleep = 0, pin_n = 1;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        pready, pslverr, er, full, warm, inhibit, preset, clr_pc, psl;
  int          err_total = 0, n_checks = 0, fulls = 0, f0;
  // short counts keep the overflow run near a thousand cycles
  watchdog_and_reset_control #(.SOFT_CYCLES(4), .PIN_CYCLES(4),
    .SLOW_DIV(4)) dut_u (.CLOCK(clock), .RST_N(rst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SLEEP_MODE(sleep), .EXTERNAL_CLEAR_PIN_N(pin_n), .FULL_RESET(full),
    .WARM_RESET(warm), .CORE_INHIBIT(inhibit), .PORT_PRESET(preset),
    .CLEAR_PC(clr_pc), .PIN_RESET_SELECT(psl));
  initial
  begin
    forever #4 clock = ~clock;
  end
  always @(posedge clock)
    fulls <= fulls + full;
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input int d);
    @(posedge clock);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
      @(posedge clock);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] a, input int e, input string nm);
    apb(0, a, 0);
    chk(nm, rd, e);
  endtask
  task automatic wt(input bit s, input int lim);
    int n;
    n = 0;
    while ((s ? warm : full) !== 1'b1 && n++ < lim)
      @(posedge clock);
  endtask
  task automatic settle();
    repeat (20) @(posedge clock);
  endtask
  task automatic t_keys();
    rdc(`ADDR_WATCHDOG_CONTROL, `WDT_CTRL_POR, "wctl");
    rdc(`ADDR_RESET_PIN_KEY, `PIN_KEY_POR, "pkey");
    chk("preset_off", preset, 0);
    chk("psel", psl, 1);
    rdc(12'h014, 0, "unmapped");
    chk("slverr", er, 1);
    apb(1, `ADDR_WATCHDOG_CONTROL, 32'hab);
    rdc(`ADDR_WATCHDOG_CONTROL, 32'hab, "wkey_b");
    apb(1, `ADDR_WATCHDOG_CONTROL, 32'h03);
    wt(0, 30);
    chk("wkey_rst", full, 1);
    settle();
    rdc(`ADDR_RESET_SOURCE_FLAGS, 32'h01, "wflag");
    apb(1, `ADDR_RESET_SOURCE_FLAGS, 32'hf0);
    rdc(`ADDR_RESET_SOURCE_FLAGS, 0, "flags0");
    apb(1, `ADDR_RESET_PIN_KEY, `PIN_KEY_B);
    rdc(`ADDR_RESET_PIN_KEY, `PIN_KEY_B, "pkey_b");
    apb(1, `ADDR_RESET_PIN_KEY, 32'h12);
    wt(0, 30);
    chk("pkey_rst", full, 1);
    settle();
    rdc(`ADDR_RESET_SOURCE_FLAGS, 32'h08, "pflag");
    rdc(`ADDR_RESET_PIN_KEY, `PIN_KEY_POR, "pkey_por");
    $display("keys done");
  endtask
  task automatic t_pin();
    pin_n <= 1'b0;
    repeat (8) @(posedge clock);
    chk("pin_rst", full, 1);
    chk("clr_pc", clr_pc, 1);
    pin_n <= 1'b1;
    @(posedge clock);
    chk("inhibit", inhibit, 1);
    settle();
    chk("resume", inhibit, 0);
    $display("pin done");
  endtask
  task automatic t_wdt();
    apb(1, `ADDR_WATCHDOG_CONTROL, 32'h50);
    f0 = fulls;
    repeat (3)
    begin
      repeat (600) @(posedge clock);
      apb(1, `ADDR_CORE_EVENTS, 32'h1);
    end
    chk("kept", fulls, f0);
    wt(0, 1100);
    chk("ovf", full, 1);
    settle();
    rdc(`ADDR_CORE_STATUS, 32'h1, "expired");
    apb(1, `ADDR_WATCHDOG_CONTROL, 32'h50);
    apb(1, `ADDR_RESET_PIN_KEY, `PIN_KEY_B);
    sleep <= 1'b1;
    f0 = fulls;
    wt(1, 1100);
    chk("warm", warm, 1);
    settle();
    chk("no_full", fulls, f0);
    sleep <= 1'b0;
    rdc(`ADDR_RESET_PIN_KEY, `PIN_KEY_B, "pkey_kept");
    apb(1, `ADDR_CORE_EVENTS, 32'h2);
    rdc(`ADDR_CORE_STATUS, 32'h2, "stop");
    $display("wdt done");
  endtask
  task automatic t_sel();
    apb(1, `ADDR_WATCHDOG_CONTROL, 32'h51);
    apb(1, `ADDR_CORE_EVENTS, 32'h1);
    f0 = fulls;
    repeat (1900) @(posedge clock);
    chk("sel1_early", fulls, f0);
    wt(0, 300);
    chk("sel1_ovf", full, 1);
    $display("select done");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    chk("preset", preset, 1);
    t_keys();
    t_pin();
    t_wdt();
    t_sel();
    stop_test();
  end
  initial
  begin
    #100000;
    err_total++;
    stop_test();
  end
endmodule // watchdog_and_reset_control_bench
`default_nettype wire
